// ===== sfpi_device.sv
// flash device end of the serial pin link
//
// What this block does
// - select high enters standby unless busy
// - select high ignores inputs other than the dedicated reset pin, floats outputs
// - dedicated reset pin works while deselected
// - select low makes device active
// - host drops select before first command
// - command bits taken on rising clock
// - single rate: sample rise, drive fall
// - double rate: sample and drive both edges
// - reset low resets, outputs float
// - host avoids reset during internal write; the host here has no busy input and drives reset whenever it is idle
// - config bit 4 disables reset
// - shared reset inactive in quad protocol
// - pause freezes link, floats outputs
// - config bit 4 disables pause
// - shared pause off in quad or double rate
// - protect bit with low write-protect blocks status writes
// - write-protect pin becomes lane 2 in quad
// - host drives write-protect lane except while quad data is read
// - single commands: lane 0 in, lane 1 out
// - dual: lanes 1 and 0 both ways
// - quad: all four lanes both ways
// - protect enable is status bit 7
// - protected state left by write-protect high
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module sfpi_device
  import sfpi_pkg::*;
#(
  parameter bit SHARED_RESET   = 1'b0,
  parameter bit PAUSE_ON_LANE3 = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  sfpi_link_if.dev        link,
  input  wire logic       busy,
  input  wire logic [7:0] nv_cfg,
  input  wire logic [7:0] read_byte,
  output logic      [7:0] status_reg,
  output logic      [7:0] vol_cfg,
  output logic            standby
);
  // ************************************************************
  // parameter check
  // ************************************************************
  if (SHARED_RESET && PAUSE_ON_LANE3) begin : g_bad_variant
    $error("lane 3 cannot carry both reset and pause");
  end

  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_CMD  = 5'b00010,
    D_RX   = 5'b00100,
    D_TX   = 5'b01000,
    D_SKIP = 5'b10000
  } sfpi_dstate_type;

  // ************************************************************
  // pin sampling and edges
  // ************************************************************
  logic [6:0]      pin_s;
  logic            rst_pin;
  logic            sel_s;
  logic            sclk_s;
  logic [3:0]      lane_s;
  logic            sclk_d;
  sfpi_dstate_type state;
  logic [7:0]      sh;
  logic [3:0]      cnt;
  logic [7:0]      cmd;
  logic [1:0]      data_w;
  logic            tx_live;
  logic [1:0]      proto;
  logic            dtr;
  logic            pin_en;
  logic [1:0]      cmd_w;
  logic            lane3_data;
  logic            hw_reset;
  logic            paused;
  logic            take_rise;
  logic            take_fall;
  logic            rx_edge;
  logic            tx_edge;
  logic [7:0]      next_sh;
  logic [3:0]      next_cnt;
  logic            commit;
  logic            sr_blocked;

  sfpi_sync #(.WIDTH(7), .RESET_VAL(7'h60)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({link.rst_n, link.sel_n, link.sclk, link.lane}),
    .dout    (pin_s)
  );

  assign {rst_pin, sel_s, sclk_s, lane_s} = pin_s;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // ************************************************************
  // mode decode
  // ************************************************************
  assign proto      = vol_cfg[VCFG_PROTO_LSB +: 2];
  assign dtr        = vol_cfg[VCFG_DTR_BIT];
  assign pin_en     = nv_cfg[CFG_PIN_EN_BIT] & vol_cfg[CFG_PIN_EN_BIT];
  assign cmd_w      = (proto == QUAD_IO_PROTOCOL) ? W_X4 :
                      (proto == DUAL_IO_PROTOCOL) ? W_X2 : W_X1;
  assign lane3_data = (proto == QUAD_IO_PROTOCOL) ||
                      ((state == D_RX || state == D_TX) && data_w == W_X4);
  // dedicated pin is honoured even while deselected
  assign hw_reset   = pin_en & (SHARED_RESET ? (~lane_s[3] & ~sel_s & ~lane3_data)
                                             : ~rst_pin);
  assign paused     = PAUSE_ON_LANE3 & pin_en & ~sel_s & ~dtr & ~lane3_data
                      & ~lane_s[3];
  assign take_rise  = ~sel_s & ~paused & sclk_s & ~sclk_d;
  assign take_fall  = ~sel_s & ~paused & ~sclk_s & sclk_d;
  assign rx_edge    = take_rise | (dtr & take_fall);
  assign tx_edge    = take_fall | (dtr & take_rise);

  function automatic logic [1:0] width_for(input logic [7:0] c);
    if (proto != EXTENDED_IO_PROTOCOL) begin
      width_for = cmd_w;
    end else if (c == CMD_QUAD_OUTPUT_FAST_READ) begin
      width_for = W_X4;
    end else if (c == CMD_DUAL_OUTPUT_READ) begin
      width_for = W_X2;
    end else begin
      width_for = W_X1;
    end
  endfunction : width_for

  function automatic logic [7:0] pick_byte(input logic [7:0] c);
    pick_byte = (c == CMD_READ_STATUS) ? status_reg :
                (c == CMD_READ_VCFG) ? vol_cfg : read_byte;
  endfunction : pick_byte

  always_comb begin
    if (state == D_CMD) begin
      next_sh  = shift_in(sh, lane_s, cmd_w, 1'b1);
      next_cnt = cnt + lane_count(cmd_w);
    end else if (state == D_RX) begin
      next_sh  = shift_in(sh, lane_s, data_w, 1'b1);
      next_cnt = cnt + lane_count(data_w);
    end else begin
      next_sh  = shift_out(sh, data_w);
      next_cnt = cnt + lane_count(data_w);
    end
  end

  assign commit     = (state == D_RX) & rx_edge & (next_cnt == 4'h8);
  assign sr_blocked = status_reg[SR_PROTECT_BIT] & ~lane_s[2]
                      & (proto != QUAD_IO_PROTOCOL);

  // ************************************************************
  // serial sequencer
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= D_IDLE;
      sh      <= 8'h00;
      cnt     <= 4'h0;
      cmd     <= 8'h00;
      data_w  <= W_X1;
      tx_live <= 1'b0;
      link.d_out <= 4'h0;
    end else if (hw_reset || sel_s) begin
      state   <= D_IDLE;
      cnt     <= 4'h0;
      tx_live <= 1'b0;
    end else begin
      unique case (state)
        D_IDLE: begin
          state <= D_CMD;
          cnt   <= 4'h0;
        end
        D_CMD: begin
          if (take_rise) begin
            sh  <= next_sh;
            cnt <= next_cnt;
            if (next_cnt == 4'h8) begin
              cmd    <= next_sh;
              cnt    <= 4'h0;
              data_w <= width_for(next_sh);
              if (next_sh == CMD_WRITE_STATUS || next_sh == CMD_WRITE_VCFG) begin
                state <= D_RX;
              end else if (next_sh == CMD_READ_STATUS || next_sh == CMD_READ_VCFG ||
                           next_sh == CMD_READ || next_sh == CMD_DUAL_OUTPUT_READ ||
                           next_sh == CMD_QUAD_OUTPUT_FAST_READ) begin
                state <= D_TX;
                sh    <= pick_byte(next_sh);
              end else begin
                state <= D_SKIP;
              end
            end
          end
        end
        D_RX: begin
          if (rx_edge) begin
            sh    <= next_sh;
            cnt   <= next_cnt;
            state <= (next_cnt == 4'h8) ? D_SKIP : D_RX;
          end
        end
        D_TX: begin
          if (tx_edge) begin
            link.d_out <= lane_out(sh, data_w, 1'b1);
            tx_live    <= 1'b1;
            sh         <= (next_cnt == 4'h8) ? pick_byte(cmd) : next_sh;
            cnt        <= (next_cnt == 4'h8) ? 4'h0 : next_cnt;
          end
        end
        D_SKIP: begin
          state <= D_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.d_oe <= 4'h0;
    end else if (tx_live && state == D_TX && !paused && !sel_s && !hw_reset) begin
      link.d_oe <= send_mask(data_w, 1'b1);
    end else begin
      link.d_oe <= 4'h0;
    end
  end

  // ************************************************************
  // device registers
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= SR_RESET;
    end else if (commit && cmd == CMD_WRITE_STATUS && !sr_blocked) begin
      status_reg <= {next_sh[7:2], 1'b0, busy};
    end else begin
      status_reg <= {status_reg[7:2], 1'b0, busy};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vol_cfg <= VCFG_RESET;
    end else if (hw_reset) begin
      vol_cfg <= VCFG_RESET;
    end else if (commit && cmd == CMD_WRITE_VCFG) begin
      vol_cfg <= next_sh;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      standby <= 1'b1;
    end else begin
      standby <= sel_s & ~busy;
    end
  end
endmodule : sfpi_device

// ===== sfpi_pkg.sv
// shared constants and lane helpers for the serial flash pin link
package sfpi_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS       = 5;
  localparam int LINK_HALF_NS = 80;
  localparam int HALF_CYCLES  = LINK_HALF_NS / CLK_NS;
  localparam int MIN_HALF     = 8;

  // ************************************************************
  // lane widths and protocols
  // ************************************************************
  localparam logic [1:0] W_X1                 = 2'h0;
  localparam logic [1:0] W_X2                 = 2'h1;
  localparam logic [1:0] W_X4                 = 2'h2;
  localparam logic [1:0] EXTENDED_IO_PROTOCOL = 2'h0;
  localparam logic [1:0] DUAL_IO_PROTOCOL     = 2'h1;
  localparam logic [1:0] QUAD_IO_PROTOCOL     = 2'h2;

  // ************************************************************
  // device commands and register fields
  // ************************************************************
  localparam logic [7:0] CMD_WRITE_STATUS          = 8'h01;
  localparam logic [7:0] CMD_READ                  = 8'h03;
  localparam logic [7:0] CMD_READ_STATUS           = 8'h05;
  localparam logic [7:0] CMD_DUAL_OUTPUT_READ      = 8'h3B;
  localparam logic [7:0] CMD_QUAD_OUTPUT_FAST_READ = 8'h6B;
  localparam logic [7:0] CMD_WRITE_VCFG            = 8'h81;
  localparam logic [7:0] CMD_READ_VCFG             = 8'h85;
  localparam int         CFG_PIN_EN_BIT            = 4;
  localparam int         VCFG_DTR_BIT              = 5;
  localparam int         VCFG_PROTO_LSB            = 6;
  localparam logic [7:0] VCFG_RESET                = 8'h10;
  localparam int         SR_PROTECT_BIT            = 7;
  localparam logic [7:0] SR_RESET                  = 8'h00;

  // ************************************************************
  // host registers
  // ************************************************************
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_DATA       = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;
  localparam logic [7:0]  REG_DIV        = 8'h0C;
  localparam int          CTL_CMD_LSB    = 0;
  localparam int          CTL_CW_LSB     = 8;
  localparam int          CTL_DW_LSB     = 10;
  localparam int          CTL_DTR_BIT    = 12;
  localparam int          CTL_READ_BIT   = 13;
  localparam int          CTL_NODATA_BIT = 14;
  localparam int          CTL_GO_BIT     = 15;
  localparam int          CTL_WP_BIT     = 16;
  localparam int          CTL_HOLD_BIT   = 17;
  localparam int          CTL_RST_BIT    = 18;
  localparam logic [31:0] CTRL_RESET     = 32'h0007_0000;

  // ************************************************************
  // lane helpers
  // ************************************************************
  function automatic logic [3:0] lane_count(input logic [1:0] w);
    lane_count = (w == W_X4) ? 4'h4 : (w == W_X2) ? 4'h2 : 4'h1;
  endfunction : lane_count

  function automatic logic [3:0] used_mask(input logic [1:0] w);
    used_mask = (w == W_X4) ? 4'hF : 4'h3;
  endfunction : used_mask

  function automatic logic [3:0] send_mask(input logic [1:0] w, input logic dev);
    send_mask = (w == W_X4) ? 4'hF : (w == W_X2) ? 4'h3 : (dev ? 4'h2 : 4'h1);
  endfunction : send_mask

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] din,
                                          input logic [1:0] w, input logic dev);
    if (w == W_X4) begin
      shift_in = {sh[3:0], din};
    end else if (w == W_X2) begin
      shift_in = {sh[5:0], din[1:0]};
    end else begin
      shift_in = {sh[6:0], (dev ? din[0] : din[1])};
    end
  endfunction : shift_in

  function automatic logic [3:0] lane_out(input logic [7:0] sh, input logic [1:0] w,
                                          input logic dev);
    if (w == W_X4) begin
      lane_out = sh[7:4];
    end else if (w == W_X2) begin
      lane_out = {2'h0, sh[7:6]};
    end else begin
      lane_out = dev ? {2'h0, sh[7], 1'b0} : {3'h0, sh[7]};
    end
  endfunction : lane_out

  function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic [1:0] w);
    shift_out = (w == W_X4) ? {sh[3:0], 4'h0} : (w == W_X2) ? {sh[5:0], 2'h0}
                                             : {sh[6:0], 1'b0};
  endfunction : shift_out
endpackage : sfpi_pkg

// ===== sfpi_link_if.sv
// pin level link between host and flash device
`timescale 1ns/1ps
interface sfpi_link_if;
  logic       sel_n;
  logic       sclk;
  logic       rst_n;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  logic [3:0] lane;

  // board pull-up where nobody drives
  assign lane = (h_oe & h_out) | (~h_oe & d_oe & d_out) | (~h_oe & ~d_oe);

  modport host (output sel_n, output sclk, output rst_n, output h_out, output h_oe,
                input lane);
  modport dev  (input sel_n, input sclk, input rst_n, input lane, output d_out,
                output d_oe);
endinterface : sfpi_link_if

// ===== sfpi_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfpi_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sfpi_sync

// ===== sfpi_host.sv
// host controller end of the serial pin link, apb programmed
`timescale 1ns/1ps
module sfpi_host
  import sfpi_pkg::*;
#(
  parameter logic [15:0] DIV_RESET = 16'(HALF_CYCLES)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sfpi_link_if.host        link
);
  if (DIV_RESET < MIN_HALF) begin : g_bad_div
    $error("half period too short for pin synchronisers");
  end

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_LEAD  = 4'b0010,
    H_SHIFT = 4'b0100,
    H_TAIL  = 4'b1000
  } sfpi_hstate_type;

  // ************************************************************
  // apb registers
  // ************************************************************
  sfpi_hstate_type state;
  logic [31:0]     ctrl;
  logic [7:0]      tx_byte;
  logic [7:0]      rx_byte;
  logic [15:0]     div;
  logic [15:0]     pcnt;
  logic [3:0]      lane_s;
  logic [7:0]      sh;
  logic [3:0]      bcnt;
  logic            in_data;
  logic            primed;
  logic            setup;
  logic            wr;
  logic            go;
  logic            phase_end;
  logic            mid;
  logic [1:0]      cw;
  logic [1:0]      dw;
  logic            rd;
  logic            dtr;
  logic [3:0]      idle_out;
  logic [3:0]      cur_cnt;
  logic [1:0]      cur_w;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready & pwrite;
  assign go    = wr & (paddr == REG_CTRL) & pwdata[CTL_GO_BIT] & (state == H_IDLE);
  assign cw    = ctrl[CTL_CW_LSB +: 2];
  assign dw    = ctrl[CTL_DW_LSB +: 2];
  assign rd    = ctrl[CTL_READ_BIT];
  assign dtr   = ctrl[CTL_DTR_BIT];
  assign idle_out  = {ctrl[CTL_HOLD_BIT], ctrl[CTL_WP_BIT], 2'h0};
  assign phase_end = (pcnt == div - 16'h1);
  assign mid       = (pcnt == (div >> 1));
  assign cur_w     = in_data ? dw : cw;
  assign cur_cnt   = bcnt + lane_count(cur_w);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & (paddr != REG_CTRL) & (paddr != REG_DATA) &
                 (paddr != REG_STATUS) & (paddr != REG_DIV);
      unique case (paddr)
        REG_CTRL:   prdata <= ctrl;
        REG_DATA:   prdata <= {24'h0, rx_byte};
        REG_STATUS: prdata <= {31'h0, (state != H_IDLE)};
        REG_DIV:    prdata <= {16'h0, div};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl    <= CTRL_RESET;
      tx_byte <= 8'h00;
      div     <= DIV_RESET;
    end else if (wr && state == H_IDLE) begin
      // reset bit only changes between transfers; the pin follows it one clock later
      if (paddr == REG_CTRL) ctrl <= pwdata & ~(32'h1 << CTL_GO_BIT);
      if (paddr == REG_DATA) tx_byte <= pwdata[7:0];
      if (paddr == REG_DIV) div <= (pwdata[15:0] < 16'(MIN_HALF)) ? 16'(MIN_HALF)
                                                                   : pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.rst_n <= 1'b1;
    end else begin
      link.rst_n <= ctrl[CTL_RST_BIT];
    end
  end

  sfpi_sync #(.WIDTH(4), .RESET_VAL(4'hF)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (link.lane),
    .dout    (lane_s)
  );

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= H_IDLE;
      pcnt       <= 16'h0;
      sh         <= 8'h00;
      bcnt       <= 4'h0;
      in_data    <= 1'b0;
      primed     <= 1'b0;
      rx_byte    <= 8'h00;
      link.sel_n <= 1'b1;
      link.sclk  <= 1'b0;
    end else begin
      pcnt <= (state == H_IDLE || phase_end) ? 16'h0 : pcnt + 16'h1;
      unique case (state)
        H_IDLE: begin
          if (go) begin
            state      <= H_LEAD;
            link.sel_n <= 1'b0;
            sh         <= pwdata[CTL_CMD_LSB +: 8];
            bcnt       <= 4'h0;
            in_data    <= 1'b0;
            primed     <= 1'b0;
          end
        end
        H_LEAD: begin
          if (phase_end) state <= H_SHIFT;
        end
        H_SHIFT: begin
          if (phase_end) begin
            link.sclk <= ~link.sclk;
            if (!link.sclk || (in_data && dtr && (!rd || primed))) begin
              bcnt <= cur_cnt;
              sh   <= (in_data && rd) ? shift_in(sh, lane_s, dw, 1'b0)
                                      : shift_out(sh, cur_w);
              if (cur_cnt == 4'h8) begin
                bcnt <= 4'h0;
                if (!in_data && !ctrl[CTL_NODATA_BIT]) begin
                  in_data <= 1'b1;
                  sh      <= tx_byte;
                end else begin
                  state <= H_TAIL;
                  if (in_data && rd) rx_byte <= shift_in(sh, lane_s, dw, 1'b0);
                end
              end
            end
            if (link.sclk && in_data) primed <= 1'b1;
          end
        end
        H_TAIL: begin
          if (phase_end) begin
            if (link.sclk) begin
              link.sclk <= 1'b0;
            end else if (!link.sel_n) begin
              link.sel_n <= 1'b1;
            end else begin
              state <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // lane drivers
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.h_out <= 4'hC;
      link.h_oe  <= 4'hD;
    end else if (state == H_TAIL) begin
      // lanes stay released until the device has let go
      if (link.sel_n && pcnt == 16'h3) begin
        link.h_out <= idle_out;
        link.h_oe  <= 4'hD;
      end
    end else if (state != H_SHIFT) begin
      link.h_out <= idle_out;
      link.h_oe  <= 4'hD;
    end else if (mid) begin
      if (in_data && rd) begin
        link.h_oe  <= 4'hC & ~used_mask(dw);
        link.h_out <= idle_out & ~used_mask(dw);
      end else if (!link.sclk || (in_data && dtr)) begin
        link.h_oe  <= send_mask(cur_w, 1'b0) | (4'hC & ~used_mask(cur_w));
        link.h_out <= lane_out(sh, cur_w, 1'b0) | (idle_out & ~used_mask(cur_w));
      end
    end
  end
endmodule : sfpi_host

// ===== sfpi_link_chk.sv
// pin link checks between host and device
`timescale 1ns/1ps
module sfpi_link_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       sel_n,
  input wire logic       sclk,
  input wire logic       rst_n,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_desel_float: assert property (sel_n [*5] |-> d_oe == 4'h0)
    else $error("drive while deselected");
  a_reset_float: assert property (!rst_n [*5] |-> d_oe == 4'h0)
    else $error("drive in reset");
  a_frame_quiet: assert property ($fell(sel_n) |-> d_oe == 4'h0)
    else $error("drive at frame start");
  a_clk_selected: assert property ($rose(sclk) |-> !sel_n)
    else $error("clock while deselected");
  a_select_lead: assert property ($fell(sel_n) |-> !sclk [*8])
    else $error("short select lead");
  a_idle_low: assert property (sel_n |-> !sclk)
    else $error("clock high while idle");
  a_no_contend: assert property ((h_oe & d_oe) == 4'h0)
    else $error("lane driven twice");
  a_pins_held: assert property (sel_n [*5] |-> h_oe[3:2] == 2'h3)
    else $error("lanes 3 and 2 float");
  c_frame: cover property ($fell(sel_n));
  c_quad: cover property (d_oe == 4'hF);
  c_single: cover property (d_oe == 4'h2);
endmodule : sfpi_link_chk

// ===== tb_top.sv
// bench for host and device joined by the pin link
`timescale 1ns/1ps
module tb_top
  import sfpi_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy = 1'b0;
  logic [7:0]  status_reg;
  logic [7:0]  vol_cfg;
  logic        standby;
  logic [31:0] rd;
  logic        perr;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  sfpi_link_if sfpi_link_if_i ();
  sfpi_host sfpi_host_i (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(sfpi_link_if_i.host));
  sfpi_device sfpi_device_i (.clk(clk), .sys_rst(sys_rst), .link(sfpi_link_if_i.dev),
    .busy(busy), .nv_cfg(8'h10), .read_byte(8'h5A), .status_reg(status_reg),
    .vol_cfg(vol_cfg), .standby(standby));
  sfpi_link_chk sfpi_link_chk_i (.clk(clk), .sys_rst(sys_rst), .sel_n(sfpi_link_if_i.sel_n),
    .sclk(sfpi_link_if_i.sclk), .rst_n(sfpi_link_if_i.rst_n), .h_oe(sfpi_link_if_i.h_oe),
    .d_oe(sfpi_link_if_i.d_oe));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // one framed command, then wait for the host to go idle
  task automatic frame(input logic [7:0] cmd, input logic [1:0] w, input logic rx,
                       input logic wp, input logic [7:0] tx);
    apb(REG_DATA, 1'b1, {24'h0, tx});
    apb(REG_CTRL, 1'b1, (32'hF << CTL_GO_BIT) & ~(32'(!wp) << CTL_WP_BIT)
        | (32'(rx) << CTL_READ_BIT) | (32'(w) << CTL_DW_LSB) | 32'(cmd));
    do apb(REG_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask : frame
  task automatic t_status();
    apb(REG_CTRL, 1'b0, 32'h0);
    check(rd, CTRL_RESET);
    apb(8'h10, 1'b0, 32'h0);
    check({perr, rd[30:0]}, 32'h8000_0000);
    frame(CMD_WRITE_STATUS, W_X1, 1'b0, 1'b1, 8'h84);
    check({24'h0, status_reg}, 32'h84);
    frame(CMD_WRITE_STATUS, W_X1, 1'b0, 1'b0, 8'h00);
    check({24'h0, status_reg}, 32'h84);
    frame(CMD_READ_STATUS, W_X1, 1'b1, 1'b1, 8'h00);
    apb(REG_DATA, 1'b0, 32'h0);
    check(rd, 32'h84);
    frame(CMD_WRITE_STATUS, W_X1, 1'b0, 1'b1, 8'h00);
    check({24'h0, status_reg}, 32'h0);
  endtask : t_status
  task automatic t_reads();
    logic [7:0] cmds [3] = '{CMD_READ, CMD_DUAL_OUTPUT_READ, CMD_QUAD_OUTPUT_FAST_READ};
    logic [1:0] ws [3] = '{W_X1, W_X2, W_X4};
    for (int i = 0; i < 3; i++) begin
      frame(cmds[i], ws[i], 1'b1, 1'b1, 8'h00);
      apb(REG_DATA, 1'b0, 32'h0);
      check(rd, 32'h5A);
    end
  endtask : t_reads
  task automatic t_misc();
    check({31'h0, standby}, 32'h1);
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    check({31'h0, standby}, 32'h0);
    busy <= 1'b0;
    frame(CMD_WRITE_VCFG, W_X1, 1'b0, 1'b1, 8'h30);
    check({24'h0, vol_cfg}, 32'h30);
    apb(REG_CTRL, 1'b1, 32'h0003_0000);
    repeat (10) @(posedge clk);
    check({24'h0, vol_cfg}, {24'h0, VCFG_RESET});
    apb(REG_CTRL, 1'b1, CTRL_RESET);
  endtask : t_misc
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_status();
    t_reads();
    t_misc();
    complete_run();
  end
endmodule : tb_top
